// ---- include/rdeng_pkg.sv ----
// shared constants and types of the serial memory read engine
package rdeng_pkg;

  localparam int               ADDR_W     = 16;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP  = 16'h0001;
  localparam logic [ADDR_W-1:0] LAST_DEF   = 16'hFFFF;

  // slave byte: identifier nibble, select bits, read flag in bit 0
  localparam logic [3:0] ID_ARRAY = 4'hA;
  localparam logic [3:0] ID_CTRL  = 4'hD;
  localparam logic [2:0] DEV_SEL  = 3'h7;

  // bit counter values within one nine-clock byte slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_ONE   = 4'h1;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [3:0] BIT_END   = 4'h9;

  typedef enum logic {
    SPACE_ARRAY,
    SPACE_CTRL
  } space_type;

  typedef struct packed {
    space_type         space;
    logic [ADDR_W-1:0] addr;
  } fetch_type;

  typedef enum logic [2:0] {
    S_IDLE,
    S_SLAVE,
    S_WADDR,
    S_TX,
    S_WAIT
  } link_state_type;

endpackage : rdeng_pkg

// ---- core/sync2.sv ----
// two-flop synchroniser for levels entering a clock domain
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o  <= meta;
  end
endmodule : sync2
`default_nettype wire

// ---- core/word_xfer.sv ----
// toggle handshake carrying one word between two clock domains
`timescale 1ns/100ps
`default_nettype none
module word_xfer #(
  parameter int WIDTH = 8
) (
  input  wire logic             src_clk_i,
  input  wire logic             src_rst_i,
  input  wire logic             send_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic                  busy_o,
  input  wire logic             dst_clk_i,
  input  wire logic             dst_rst_i,
  output logic                  valid_o,
  output logic      [WIDTH-1:0] data_o
);
  logic             req_tgl;
  logic             req_s;
  logic             ack_s;
  logic             seen;
  logic [WIDTH-1:0] hold;

  // a send while busy is dropped; hold stays still until acknowledged
  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      req_tgl <= 1'b0;
      hold    <= '0;
    end else if (send_i && !busy_o) begin
      req_tgl <= ~req_tgl;
      hold    <= data_i;
    end
  end

  assign busy_o = req_tgl ^ ack_s;

  sync2 #(.WIDTH(1)) u_req_sync (
    .clk_i (dst_clk_i),
    .d_i   (req_tgl),
    .q_o   (req_s)
  );

  sync2 #(.WIDTH(1)) u_ack_sync (
    .clk_i (src_clk_i),
    .d_i   (seen),
    .q_o   (ack_s)
  );

  // hold is quiet for two destination edges before it is taken
  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      seen    <= 1'b0;
      valid_o <= 1'b0;
      data_o  <= '0;
    end else begin
      seen    <= req_s;
      valid_o <= req_s ^ seen;
      if (req_s ^ seen) begin
        data_o <= hold;
      end
    end
  end
endmodule : word_xfer
`default_nettype wire

// ---- core/serial_memory_read_engine.sv ----
// two-wire slave read sequencer with read address counter and prefetch
//
// How it works
// - counter holds last read address plus one
// - counter clears to zero at reset
// - matching read slave byte: acknowledge, send byte
// - dummy write: acknowledge slave and address bytes
// - repeated start read: acknowledge, return data
// - stop after address loads counter, standby
// - next current read uses loaded address
// - each master acknowledge requests another byte
// - send per acknowledge until no-ack
// - counter increments across page boundaries
// - counter wraps at end of space
// - upper nibble selects array or control space
// - no acknowledge for unmatched slave byte
// - no-ack after byte: stop sending, wait
`timescale 1ns/100ps
`default_nettype none
module serial_memory_read_engine #(
  parameter logic [15:0] LAST_ADDR = rdeng_pkg::LAST_DEF
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 link_clk_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  output logic                      mem_req_o,
  output rdeng_pkg::fetch_type      mem_fetch_o,
  input  wire logic                 mem_ack_i,
  input  wire logic [7:0]           mem_data_i
);

  // ----------------------------------------------------------------
  // pin sampling and bus conditions
  // ----------------------------------------------------------------
  logic                     rst_l;
  logic                     scl_s;
  logic                     sda_s;
  logic                     scl_q;
  logic                     sda_q;
  rdeng_pkg::link_state_type state;
  logic [3:0]               bitcnt;
  logic [7:0]               shreg;
  logic                     rw;
  logic                     mack;
  logic                     drive;
  rdeng_pkg::space_type     space;
  logic [15:0]              rd_addr;
  logic [15:0]              waddr;
  logic                     waddr_lo;
  logic                     pend;
  logic [7:0]               pf_data;
  logic                     pf_valid;
  logic                     fetch_send;
  rdeng_pkg::fetch_type     fetch;
  logic                     resp_valid;
  logic [7:0]               resp_data;
  rdeng_pkg::fetch_type     req_data;
  logic                     req_valid;

  // reset reaches the link domain through the same two flops
  sync2 #(.WIDTH(3)) u_pin_sync (
    .clk_i (link_clk_i),
    .d_i   ({rst_i, scl_i, sda_i}),
    .q_o   ({rst_l, scl_s, sda_s})
  );

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  wire at_ack   = bitcnt == rdeng_pkg::BIT_ACK;
  wire at_end   = bitcnt == rdeng_pkg::BIT_END;

  function automatic logic id_ok(input logic [7:0] b);
    id_ok = (b[7:4] == rdeng_pkg::ID_ARRAY ||
             b[7:4] == rdeng_pkg::ID_CTRL) &&
            b[3:1] == rdeng_pkg::DEV_SEL;
  endfunction : id_ok

  function automatic logic [15:0] step_addr(input logic [15:0] a);
    step_addr = (a == LAST_ADDR) ? rdeng_pkg::RESET_ADDR
                                 : a + rdeng_pkg::ADDR_STEP;
  endfunction : step_addr

  wire slave_fall = state == rdeng_pkg::S_SLAVE && scl_fall;
  wire waddr_fall = state == rdeng_pkg::S_WADDR && scl_fall;
  wire tx_fall    = state == rdeng_pkg::S_TX && scl_fall;
  wire match      = slave_fall && at_ack && id_ok(shreg);
  wire tx_load    = (slave_fall && at_end && rw) ||
                    (tx_fall && at_end && mack);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      state  <= rdeng_pkg::S_IDLE;
      bitcnt <= rdeng_pkg::BIT_FIRST;
    end else if (start_c) begin
      state  <= rdeng_pkg::S_SLAVE;
      bitcnt <= rdeng_pkg::BIT_FIRST;
    end else if (stop_c) begin
      state <= rdeng_pkg::S_IDLE;
    end else begin
      case (state)
        rdeng_pkg::S_SLAVE, rdeng_pkg::S_WADDR,
        rdeng_pkg::S_TX: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + rdeng_pkg::BIT_ONE;
          end else if (slave_fall && at_ack && !id_ok(shreg)) begin
            state <= rdeng_pkg::S_IDLE;
          end else if (slave_fall && at_end) begin
            bitcnt <= rdeng_pkg::BIT_FIRST;
            state  <= rw ? rdeng_pkg::S_TX : rdeng_pkg::S_WADDR;
          end else if (waddr_fall && at_end) begin
            bitcnt <= rdeng_pkg::BIT_FIRST;
            // write data is not taken here: leave the bus alone
            if (pend) begin
              state <= rdeng_pkg::S_WAIT;
            end
          end else if (tx_fall && at_end) begin
            bitcnt <= rdeng_pkg::BIT_FIRST;
            if (!mack) begin
              state <= rdeng_pkg::S_WAIT;
            end
          end
        end
        default: begin
          bitcnt <= rdeng_pkg::BIT_FIRST;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shift register, slave byte fields, master acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      shreg <= 8'h00;
      rw    <= 1'b0;
      space <= rdeng_pkg::SPACE_ARRAY;
      mack  <= 1'b0;
    end else if (tx_load) begin
      shreg <= pf_data;
    end else if (scl_rise && bitcnt < rdeng_pkg::BIT_ACK &&
                 state != rdeng_pkg::S_TX &&
                 state != rdeng_pkg::S_IDLE &&
                 state != rdeng_pkg::S_WAIT) begin
      shreg <= {shreg[6:0], sda_s};
    end else if (tx_fall && bitcnt > rdeng_pkg::BIT_FIRST &&
                 bitcnt < rdeng_pkg::BIT_ACK) begin
      shreg <= {shreg[6:0], 1'b0};
    end else if (state == rdeng_pkg::S_TX && scl_rise && at_ack) begin
      mack <= ~sda_s;
    end else if (match) begin
      rw    <= shreg[0];
      space <= (shreg[7:4] == rdeng_pkg::ID_CTRL) ?
               rdeng_pkg::SPACE_CTRL : rdeng_pkg::SPACE_ARRAY;
    end
  end

  // ----------------------------------------------------------------
  // data line: pulled low to send a zero or to acknowledge
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i) begin
    if (rst_l || start_c || stop_c) begin
      drive <= 1'b0;
    end else if (slave_fall && at_ack) begin
      drive <= id_ok(shreg);
    end else if (waddr_fall && at_ack) begin
      drive <= 1'b1;
    end else if (tx_load) begin
      drive <= ~pf_data[7];
    end else if ((slave_fall || waddr_fall || tx_fall) && at_end) begin
      drive <= 1'b0;
    end else if (tx_fall && at_ack) begin
      drive <= 1'b0;
    end else if (tx_fall && bitcnt > rdeng_pkg::BIT_FIRST) begin
      drive <= ~shreg[6];
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = drive;

  // ----------------------------------------------------------------
  // word address capture and read address counter
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i) begin
    if (rst_l || start_c || stop_c) begin
      waddr_lo <= 1'b0;
      pend     <= 1'b0;
    end else if (waddr_fall && at_ack) begin
      if (waddr_lo) begin
        waddr[7:0] <= shreg;
        pend       <= 1'b1;
      end else begin
        waddr[15:8] <= shreg;
        waddr_lo    <= 1'b1;
      end
    end
  end

  // a repeated start also loads, so a random read finds its address
  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      rd_addr <= rdeng_pkg::RESET_ADDR;
    end else if ((start_c || stop_c) && pend) begin
      rd_addr <= waddr;
    end else if (tx_load) begin
      rd_addr <= step_addr(rd_addr);
    end
  end

  // ----------------------------------------------------------------
  // prefetch: the next byte is fetched while the current one leaves
  // ----------------------------------------------------------------
  // limitation: the memory round trip must fit in one scl low-high
  // period, since the slave never stretches the clock
  assign fetch_send = match || tx_load;
  always_comb begin
    fetch.addr  = tx_load ? step_addr(rd_addr) : rd_addr;
    fetch.space = tx_load ? space :
                  ((shreg[7:4] == rdeng_pkg::ID_CTRL) ?
                   rdeng_pkg::SPACE_CTRL : rdeng_pkg::SPACE_ARRAY);
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_l || fetch_send) begin
      pf_valid <= 1'b0;
    end else if (resp_valid) begin
      pf_valid <= 1'b1;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_l) begin
      pf_data <= 8'h00;
    end else if (resp_valid) begin
      pf_data <= resp_data;
    end
  end

  word_xfer #(.WIDTH($bits(rdeng_pkg::fetch_type))) u_req_xfer (
    .src_clk_i (link_clk_i),
    .src_rst_i (rst_l),
    .send_i    (fetch_send),
    .data_i    (fetch),
    .busy_o    (),
    .dst_clk_i (mclk_i),
    .dst_rst_i (rst_i),
    .valid_o   (req_valid),
    .data_o    (req_data)
  );

  // ----------------------------------------------------------------
  // memory side, system clock
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_req_o   <= 1'b0;
      mem_fetch_o <= '0;
    end else if (req_valid) begin
      mem_req_o   <= 1'b1;
      mem_fetch_o <= req_data;
    end else if (mem_ack_i) begin
      mem_req_o <= 1'b0;
    end
  end

  word_xfer #(.WIDTH(8)) u_resp_xfer (
    .src_clk_i (mclk_i),
    .src_rst_i (rst_i),
    .send_i    (mem_req_o && mem_ack_i),
    .data_i    (mem_data_i),
    .busy_o    (),
    .dst_clk_i (link_clk_i),
    .dst_rst_i (rst_l),
    .valid_o   (resp_valid),
    .data_o    (resp_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (rst_l);

  chk_counter_reset: assert property (
    $fell(rst_l) |-> rd_addr == rdeng_pkg::RESET_ADDR)
    else $error("counter not zero after reset");

  chk_counter_step: assert property (
    tx_load && !start_c && !stop_c |=> rd_addr == step_addr($past(rd_addr)))
    else $error("counter did not advance by one");

  chk_counter_wrap: assert property (
    tx_load && rd_addr == LAST_ADDR |=> rd_addr == rdeng_pkg::RESET_ADDR)
    else $error("counter did not wrap");

  chk_slave_ack: assert property (
    match && !start_c && !stop_c |=> sda_oe_o ##1 (sda_oe_o || scl_s))
    else $error("matching slave byte not acknowledged");

  chk_bad_nack: assert property (
    slave_fall && at_ack && !id_ok(shreg) |=> !sda_oe_o [*2])
    else $error("unmatched slave byte acknowledged");

  chk_waddr_ack: assert property (
    waddr_fall && at_ack && !start_c && !stop_c |=> sda_oe_o)
    else $error("word address byte not acknowledged");

  chk_ack_release: assert property (
    tx_fall && at_ack && !start_c && !stop_c |=> !sda_oe_o)
    else $error("data line held in acknowledge clock");

  chk_nack_quiet: assert property (
    tx_fall && at_end && !mack && !start_c && !stop_c
    |=> state == rdeng_pkg::S_WAIT && !sda_oe_o)
    else $error("transmission went on after no-ack");

  chk_more_bytes: assert property (
    tx_fall && at_end && mack && !start_c && !stop_c
    |=> state == rdeng_pkg::S_TX && bitcnt == rdeng_pkg::BIT_FIRST)
    else $error("no further byte after acknowledge");

  chk_prefetch_ready: assert property (
    tx_load |-> pf_valid)
    else $error("byte loaded before its fetch returned");

  chk_set_address: assert property (
    stop_c && pend |=> rd_addr == $past(waddr) &&
                       state == rdeng_pkg::S_IDLE)
    else $error("stop after address did not load counter");

  cov_current_read: cover property (
    slave_fall && at_end && rw && !pend);
  cov_random_read: cover property (
    start_c && pend ##[1:400] tx_load);
  cov_sequential: cover property (tx_fall && at_end && mack);
  cov_set_address: cover property (stop_c && pend);

endmodule : serial_memory_read_engine
`default_nettype wire

// ---- bench/bus_master_model.sv ----
// two-wire bus master model: drives the serial clock, pulls data low
`timescale 1ns/100ps
`default_nettype none
module bus_master_model #(
  parameter int QTR_NS = 400
) (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ---------------------------------------------------------------
  // bus phases
  // ---------------------------------------------------------------
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // also a repeated start: data is freed while the clock is still low
  task automatic start_cond();
    sda_low_o = 1'b0;
    #(QTR_NS) scl_o = 1'b1;
    #(QTR_NS) sda_low_o = 1'b1;
    #(QTR_NS) scl_o = 1'b0;
    #(QTR_NS);
  endtask : start_cond

  task automatic stop_cond();
    sda_low_o = 1'b1;
    #(QTR_NS) scl_o = 1'b1;
    #(QTR_NS) sda_low_o = 1'b0;
    #(QTR_NS);
  endtask : stop_cond

  // data changes a quarter after the fall, is sampled mid high phase
  task automatic clock_bit(input logic val, output logic seen);
    sda_low_o = ~val;
    #(QTR_NS) scl_o = 1'b1;
    #(QTR_NS) seen = sda_i;
    #(QTR_NS) scl_o = 1'b0;
    #(QTR_NS);
  endtask : clock_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], seen);
    end
    clock_bit(1'b1, seen);
    ack = ~seen;
  endtask : send_byte

  // no-ack keeps data high through the ninth clock
  task automatic recv_byte(input logic ack, output logic [7:0] b,
                           output logic line);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, b[i]);
    end
    clock_bit(~ack, line);
  endtask : recv_byte
endmodule : bus_master_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench of the serial memory read engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic        ctrl;
    logic [15:0] addr;
    logic [3:0]  n;
    logic [15:0] next;
  } row_type;

  localparam logic [15:0] LAST = 16'h01FF;
  // random read rows: space, address, byte count, counter afterwards
  localparam row_type ROWS [4] = '{
    '{1'b0, 16'h0010, 4'h2, 16'h0012},
    '{1'b1, 16'h0005, 4'h1, 16'h0006},
    '{1'b0, 16'h00FE, 4'h4, 16'h0102},
    '{1'b0, 16'h01FE, 4'h3, 16'h0001}
  };

  logic                 mclk_i;
  logic                 rst_i;
  logic                 link_clk_i;
  logic                 scl;
  logic                 sda_low;
  wire logic            sda_line;
  logic                 sda_o;
  logic                 sda_oe_o;
  logic                 mem_req_o;
  rdeng_pkg::fetch_type mem_fetch_o;
  logic                 mem_ack_i;
  logic [7:0]           mem_data_i;
  int                   n_mismatch;
  int                   checks;
  int                   cycles;

  // pulled-up open-drain data line
  assign sda_line = ~(sda_low | (sda_oe_o & ~sda_o));

  serial_memory_read_engine #(.LAST_ADDR(LAST)) u_serial_memory_read_engine (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .link_clk_i  (link_clk_i),
    .scl_i       (scl),
    .sda_i       (sda_line),
    .sda_o       (sda_o),
    .sda_oe_o    (sda_oe_o),
    .mem_req_o   (mem_req_o),
    .mem_fetch_o (mem_fetch_o),
    .mem_ack_i   (mem_ack_i),
    .mem_data_i  (mem_data_i)
  );

  bus_master_model u_bus_master_model (
    .sda_i     (sda_line),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );

  // ---------------------------------------------------------------
  // clocks, memory answer, timeout
  // ---------------------------------------------------------------
  initial mclk_i = 1'b0;
  always #10 mclk_i = ~mclk_i;
  initial link_clk_i = 1'b0;
  always #40 link_clk_i = ~link_clk_i;

  function automatic logic [7:0] mem_byte(input logic ctrl,
                                          input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ (ctrl ? 8'hC3 : 8'h00);
  endfunction : mem_byte

  // one-cycle answer pulse, so a request is never acked twice
  always @(posedge mclk_i) begin
    #1;
    if (!rst_i && mem_req_o === 1'b1 && mem_ack_i === 1'b0) begin
      mem_ack_i  = 1'b1;
      mem_data_i = mem_byte(mem_fetch_o.space == rdeng_pkg::SPACE_CTRL,
                            mem_fetch_o.addr);
    end else begin
      mem_ack_i = 1'b0;
    end
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen,
               exp);
    end
  endtask : check

  function automatic logic [6:0] slave7(input logic ctrl);
    return {ctrl ? rdeng_pkg::ID_CTRL : rdeng_pkg::ID_ARRAY,
            rdeng_pkg::DEV_SEL};
  endfunction : slave7

  task automatic set_addr(input logic ctrl, input logic [15:0] a);
    logic ack;
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte({slave7(ctrl), 1'b0}, ack);
    check(ack, 16'h0001, "write slave ack");
    u_bus_master_model.send_byte(a[15:8], ack);
    check(ack, 16'h0001, "address high ack");
    u_bus_master_model.send_byte(a[7:0], ack);
    check(ack, 16'h0001, "address low ack");
  endtask : set_addr

  // start (or repeated start), read n bytes, no-ack the last, stop
  task automatic read_seq(input logic ctrl, input logic [15:0] first,
                          input logic [3:0] n);
    logic       ack;
    logic       line;
    logic [7:0] b;
    logic [15:0] a;
    a = first;
    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte({slave7(ctrl), 1'b1}, ack);
    check(ack, 16'h0001, "read slave ack");
    for (int k = 0; k < int'(n); k++) begin
      u_bus_master_model.recv_byte(k < int'(n) - 1, b, line);
      check(b, mem_byte(ctrl, a), "read data");
      check(line, k == int'(n) - 1, "ack slot level");
      a = (a == LAST) ? 16'h0000 : a + 16'h0001;
    end
    u_bus_master_model.stop_cond();
  endtask : read_seq

  task automatic do_reset();
    @(posedge mclk_i);
    #1 rst_i = 1'b1;
    // long enough for the link side too, which sees reset via two flops
    repeat (16) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (30) @(posedge mclk_i);
    check(mem_req_o, 16'h0000, "request after reset");
    check(sda_oe_o, 16'h0000, "data line after reset");
    check(sda_o, 16'h0000, "drive level");
  endtask : do_reset

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic       ack;
    logic       line;
    logic [7:0] b;
    n_mismatch = 0;
    checks     = 0;
    cycles     = 0;
    rst_i      = 1'b1;
    mem_ack_i  = 1'b0;
    mem_data_i = 8'h00;
    do_reset();
    foreach (ROWS[r]) begin
      set_addr(ROWS[r].ctrl, ROWS[r].addr);
      read_seq(ROWS[r].ctrl, ROWS[r].addr, ROWS[r].n);
      read_seq(ROWS[r].ctrl, ROWS[r].next, 4'h1);
      $display("test row %0d done", r);
    end

    set_addr(1'b0, 16'h0040);
    u_bus_master_model.stop_cond();
    do_reset();
    read_seq(1'b0, 16'h0000, 4'h2);
    $display("test reset done");

    set_addr(1'b0, 16'h0123);
    u_bus_master_model.stop_cond();
    for (int i = 0; i < 2; i++) begin
      u_bus_master_model.start_cond();
      u_bus_master_model.send_byte(i == 0 ? 8'hA1 : 8'h5F, ack);
      check(ack, 16'h0000, "foreign slave ack");
      u_bus_master_model.stop_cond();
    end
    read_seq(1'b0, 16'h0123, 4'h1);
    $display("test set address done");

    u_bus_master_model.start_cond();
    u_bus_master_model.send_byte({slave7(1'b0), 1'b1}, ack);
    check(ack, 16'h0001, "no-ack test slave ack");
    u_bus_master_model.recv_byte(1'b0, b, line);
    check(b, mem_byte(1'b0, 16'h0124), "byte before no-ack");
    u_bus_master_model.recv_byte(1'b0, b, line);
    check(b, 16'h00FF, "line after no-ack");
    u_bus_master_model.stop_cond();
    read_seq(1'b0, 16'h0125, 4'h1);
    $display("test no-ack done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
